// ===== rtl/pmr_pkg.sv
// pmr_pkg: constants and types of the pci burst-read master
// assumes one clock (aclk) shared by the pci pins, local side and axi4-lite slave
// How it works
// - every 64-bit local word moves as one or two 32-bit pci data phases.
// - on a 32-bit answer the unused upper local half is ignored or zeroed.
// - local side keeps whole qword; lane strobes say which dword moved.
// - qword-aligned start means first dword is lower half, else upper half.
// - core asserts pci request on the clock after seeing local request.
// - with grant and idle bus, core starts and asserts local grant.
// - after request and grant, status shows address loading.
// - core asserts frame; local master drops request after seeing address loading.
// - address phase drives address and command, status bus transaction, loads counter.
// - pci request released after frame once wide request is deasserted.
// - turnaround floats ad, drives byte enables, irdy follows ready, frame held.
// - no 64-bit acknowledge clears wide flag; local grant follows pci grant.
// - data phase completes on any clock with irdy and trdy both asserted.
// - clock after completion puts dword on its local half, decrements counter.
// - lower-lane delivery asserts low strobe and deasserts high strobe.
// - irdy stays asserted while ready held; frame held while phases remain.
// - upper-lane delivery asserts high strobe, deasserts low; strobes alternate.
// - after last phase frame then irdy drop; status termination, normal cause.
package pmr_pkg;

    // ==========================================================
    // widths
    localparam int ADDR_W = 32;
    localparam int LEN_W = 8;
    localparam int AXI_AW = 8;
    localparam logic [LEN_W-1:0] LEN_ONE = 8'h01;

    // ==========================================================
    // register map
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_COUNT = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ZERO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // local status and end cause codes
    localparam logic [3:0] LMS_IDLE = 4'h0;
    localparam logic [3:0] LMS_LOAD = 4'h1;
    localparam logic [3:0] LMS_BUS = 4'h2;
    localparam logic [3:0] LMS_TERM = 4'h3;
    localparam logic [1:0] END_NONE = 2'h0;
    localparam logic [1:0] END_NORMAL = 2'h1;
    localparam logic [1:0] END_MASTER_ABORT = 2'h2;

    // clocks allowed for devsel before abort
    localparam logic [2:0] DEVSEL_WAIT = 3'h5;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_REQ = 3'b001,
        S_GRANT = 3'b011,
        S_LOAD = 3'b010,
        S_ADDR = 3'b110,
        S_TURN = 3'b111,
        S_DATA = 3'b101,
        S_TERM = 3'b100
    } pmr_state_e;

endpackage

// ===== rtl/pmr_regs.sv
// pmr_regs: axi4-lite slave holding control and showing master state
// assumes one write and one read under way at most
`timescale 1ns/1ps
module pmr_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [pmr_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pmr_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ctrl_enable,
    output logic ctrl_zero_upper,
    input wire logic [31:0] status_word,
    input wire logic [31:0] dword_count
);
    import pmr_pkg::*;

    logic aw_full;
    logic w_full;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic w_lane0;
    logic [1:0] ctrl;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign ctrl_enable = ctrl[CTRL_EN_BIT];
    assign ctrl_zero_upper = ctrl[CTRL_ZERO_BIT];

    // ==========================================================
    // write path: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end else if (aw_full && w_full) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (aw_full && w_full) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (aw_addr == REG_CTRL) begin
                if (w_lane0) begin
                    ctrl <= w_data[1:0];
                end
            end else if (aw_addr != REG_STATUS && aw_addr != REG_COUNT) begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {30'h0, ctrl};
                REG_STATUS: s_axi_rdata <= status_word;
                REG_COUNT: s_axi_rdata <= dword_count;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== rtl/pmr_master.sv
// pmr_master: pci bus-master burst read, 32-bit pci, 64-bit local side
// assumes pci pins and local inputs are synchronous to aclk;
// the testbench resolves frame, irdy and ad from their output enables
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module pmr_master (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register port
    input wire logic [pmr_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pmr_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pci side
    output logic req_n,
    input wire logic gnt_n,
    input wire logic frame_n_in,
    output logic frame_n_out,
    output logic frame_oe,
    input wire logic irdy_n_in,
    output logic irdy_n_out,
    output logic irdy_oe,
    input wire logic trdy_n,
    input wire logic devsel_n,
    input wire logic ack64_n,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe,
    output logic [3:0] cbe_out,
    output logic cbe_oe,
    // local master side
    input wire logic local_req_narrow_n,
    input wire logic local_req_wide_n,
    input wire logic [pmr_pkg::ADDR_W-1:0] local_addr_in,
    input wire logic [3:0] local_cmd_byte_en_in,
    input wire logic [pmr_pkg::LEN_W-1:0] local_burst_len_in,
    input wire logic local_ready_n,
    output logic local_grant_n,
    output logic [3:0] local_master_state,
    output logic [1:0] end_cause_code,
    output logic [pmr_pkg::LEN_W-1:0] burst_remaining_count,
    output logic wide_transfer_active_n,
    output logic low_lane_xfer_n,
    output logic high_lane_xfer_n,
    output logic [63:0] local_data_out
);
    import pmr_pkg::*;

    pmr_state_e state;
    logic ctrl_enable;
    logic ctrl_zero_upper;
    logic bus_idle;
    logic phase_done;
    logic abort;
    logic devsel_seen;
    logic lane_hi;
    logic [2:0] devsel_wait;
    logic [31:0] dword_count;
    logic [31:0] status_word;
    logic [LEN_W-1:0] next_remaining;

    assign bus_idle = frame_n_in && irdy_n_in;
    assign phase_done = (state == S_DATA) && !irdy_n_out && !trdy_n;
    // no devsel in time: give up rather than hang the bus
    assign abort = (state == S_DATA) && !devsel_seen && (devsel_wait == DEVSEL_WAIT);
    assign next_remaining = phase_done ? burst_remaining_count - LEN_ONE
                                       : burst_remaining_count;

    // ==========================================================
    // registers
    assign status_word = {15'h0, (state != S_IDLE), burst_remaining_count,
                          2'h0, end_cause_code, local_master_state};

    pmr_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .ctrl_enable(ctrl_enable),
        .ctrl_zero_upper(ctrl_zero_upper),
        .status_word(status_word),
        .dword_count(dword_count)
    );

    // ==========================================================
    // sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (!local_req_narrow_n && ctrl_enable) begin
                        state <= S_REQ;
                    end
                end
                S_REQ: begin
                    if (!gnt_n && bus_idle) begin
                        state <= S_GRANT;
                    end
                end
                S_GRANT: begin
                    if (!gnt_n && !local_req_narrow_n) begin
                        state <= S_LOAD;
                    end else if (local_req_narrow_n) begin
                        state <= S_IDLE;
                    end else begin
                        state <= S_REQ;
                    end
                end
                S_LOAD: state <= S_ADDR;
                S_ADDR: state <= S_TURN;
                S_TURN: state <= S_DATA;
                S_DATA: begin
                    if ((phase_done && frame_n_out) || abort) begin
                        state <= S_TERM;
                    end
                end
                S_TERM: state <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // devsel watch
    always_ff @(posedge aclk) begin
        if (!aresetn || state == S_ADDR) begin
            devsel_wait <= '0;
            devsel_seen <= 1'b0;
        end else if (state == S_TURN || state == S_DATA) begin
            if (!devsel_n) begin
                devsel_seen <= 1'b1;
            end
            if (devsel_wait != DEVSEL_WAIT) begin
                devsel_wait <= devsel_wait + 3'h1;
            end
        end
    end

    // ==========================================================
    // pci request and local grant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_n <= 1'b1;
        end else if (state == S_IDLE && !local_req_narrow_n && ctrl_enable) begin
            req_n <= 1'b0;
        end else if (state == S_ADDR && local_req_wide_n) begin
            req_n <= 1'b1;
        end else if (state == S_TERM || (state == S_GRANT && local_req_narrow_n)) begin
            req_n <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_grant_n <= 1'b1;
        end else if (state == S_REQ && !gnt_n && bus_idle) begin
            local_grant_n <= 1'b0;
        end else if (state == S_TURN || state == S_DATA) begin
            local_grant_n <= gnt_n;
        end else if (state == S_TERM || state == S_IDLE) begin
            local_grant_n <= 1'b1;
        end
    end

    // ==========================================================
    // frame, irdy, ad and byte enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_n_out <= 1'b1;
            frame_oe <= 1'b0;
        end else if (state == S_LOAD) begin
            frame_n_out <= 1'b0;
            frame_oe <= 1'b1;
        end else if ((state == S_DATA && (phase_done && frame_n_out)) || abort) begin
            frame_n_out <= 1'b1;
            frame_oe <= 1'b0;
        end else if (state == S_TURN || state == S_DATA) begin
            // last phase: frame drops only together with irdy asserted
            if (!frame_n_out && next_remaining == LEN_ONE && !local_ready_n) begin
                frame_n_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irdy_n_out <= 1'b1;
            irdy_oe <= 1'b0;
        end else if (state == S_ADDR) begin
            irdy_n_out <= local_ready_n;
            irdy_oe <= 1'b1;
        end else if (state == S_TURN) begin
            irdy_n_out <= local_ready_n;
        end else if (state == S_DATA) begin
            if ((phase_done && frame_n_out) || abort) begin
                irdy_n_out <= 1'b1;
            end else if (!irdy_n_out && !phase_done) begin
                irdy_n_out <= 1'b0;
            end else begin
                irdy_n_out <= local_ready_n;
            end
        end else if (state == S_TERM) begin
            irdy_oe <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ad_out <= '0;
            ad_oe <= 1'b0;
            cbe_out <= '0;
            cbe_oe <= 1'b0;
        end else if (state == S_LOAD) begin
            ad_out <= local_addr_in;
            ad_oe <= 1'b1;
            cbe_out <= local_cmd_byte_en_in;
            cbe_oe <= 1'b1;
        end else if (state == S_ADDR || state == S_TURN ||
                     (state == S_DATA && !(phase_done && frame_n_out) && !abort)) begin
            ad_oe <= 1'b0;
            cbe_out <= local_cmd_byte_en_in;
        end else begin
            ad_oe <= 1'b0;
            cbe_oe <= 1'b0;
        end
    end

    // ==========================================================
    // local status, end cause, counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_master_state <= LMS_IDLE;
            end_cause_code <= END_NONE;
        end else begin
            unique case (state)
                S_GRANT: begin
                    if (!gnt_n && !local_req_narrow_n) begin
                        local_master_state <= LMS_LOAD;
                        end_cause_code <= END_NONE;
                    end
                end
                S_LOAD: local_master_state <= LMS_BUS;
                S_DATA: begin
                    if (phase_done && frame_n_out) begin
                        local_master_state <= LMS_TERM;
                        end_cause_code <= END_NORMAL;
                    end else if (abort) begin
                        local_master_state <= LMS_TERM;
                        end_cause_code <= END_MASTER_ABORT;
                    end
                end
                S_TERM: local_master_state <= LMS_IDLE;
                default: local_master_state <= local_master_state;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            burst_remaining_count <= '0;
        end else if (state == S_LOAD) begin
            burst_remaining_count <= local_burst_len_in;
        end else if (state == S_DATA) begin
            burst_remaining_count <= next_remaining;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dword_count <= '0;
        end else if (phase_done) begin
            dword_count <= dword_count + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wide_transfer_active_n <= 1'b1;
        end else if (state == S_TURN) begin
            wide_transfer_active_n <= ack64_n;
        end else if (state == S_IDLE) begin
            wide_transfer_active_n <= 1'b1;
        end
    end

    // ==========================================================
    // lane steering: two dwords per local qword
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lane_hi <= 1'b0;
        end else if (state == S_LOAD) begin
            lane_hi <= local_addr_in[2];
        end else if (phase_done) begin
            lane_hi <= !lane_hi;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_data_out <= '0;
            low_lane_xfer_n <= 1'b1;
            high_lane_xfer_n <= 1'b1;
        end else if (phase_done) begin
            low_lane_xfer_n <= lane_hi;
            high_lane_xfer_n <= !lane_hi;
            if (lane_hi) begin
                local_data_out[63:32] <= ad_in;
            end else begin
                local_data_out[31:0] <= ad_in;
                if (ctrl_zero_upper) begin
                    local_data_out[63:32] <= '0;
                end
            end
        end else begin
            low_lane_xfer_n <= 1'b1;
            high_lane_xfer_n <= 1'b1;
        end
    end

endmodule

// ===== verif/pmr_sva.sv
// pmr_sva: pin-level timing checks of the burst-read master
// assumes a bind into pmr_master
`timescale 1ns/1ps
module pmr_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_n,
    input wire logic local_req_narrow_n,
    input wire logic [pmr_pkg::LEN_W-1:0] local_burst_len_in,
    input wire logic local_ready_n,
    input wire logic [3:0] local_master_state,
    input wire logic frame_n_out,
    input wire logic frame_oe,
    input wire logic ad_oe,
    input wire logic irdy_n_in,
    input wire logic irdy_n_out,
    input wire logic irdy_oe,
    input wire logic trdy_n,
    input wire logic [31:0] ad_in,
    input wire logic [1:0] end_cause_code,
    input wire logic [pmr_pkg::LEN_W-1:0] burst_remaining_count,
    input wire logic low_lane_xfer_n,
    input wire logic high_lane_xfer_n,
    input wire logic [63:0] local_data_out
);
    import pmr_pkg::*;
    // ==========
    // request, address phase, data phases
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_req_cause: assert property ($fell(req_n) |-> $past(!local_req_narrow_n))
        else $error("pci request without local request");
    chk_addr_phase: assert property (local_master_state == LMS_LOAD |=>
        local_master_state == LMS_BUS && !frame_n_out && frame_oe && ad_oe
        && burst_remaining_count == $past(local_burst_len_in))
        else $error("address phase wrong after loading");
    chk_turn_irdy: assert property ($fell(ad_oe) |-> irdy_oe
        && irdy_n_out == $past(local_ready_n)) else $error("turnaround irdy wrong");
    chk_phase_done: assert property (!irdy_n_in && !trdy_n |=>
        burst_remaining_count == $past(burst_remaining_count) - LEN_ONE
        && low_lane_xfer_n != high_lane_xfer_n) else $error("completion not delivered");
    chk_low_data: assert property (!low_lane_xfer_n |-> high_lane_xfer_n
        && local_data_out[31:0] == $past(ad_in)) else $error("low lane data wrong");
    chk_high_data: assert property (!high_lane_xfer_n |-> low_lane_xfer_n
        && local_data_out[63:32] == $past(ad_in)) else $error("high lane data wrong");
    chk_lane_alt: assert property (!low_lane_xfer_n && !irdy_n_in && !trdy_n
        |=> !high_lane_xfer_n) else $error("lanes do not alternate");
    chk_term_end: assert property (local_master_state == LMS_TERM && $past(!trdy_n)
        |-> !frame_oe && irdy_n_out && end_cause_code == END_NORMAL
        ##1 local_master_state == LMS_IDLE && !irdy_oe) else $error("termination wrong");
endmodule
bind pmr_master pmr_sva u_pmr_sva (.*);

// ===== verif/pmr_target.sv
// pmr_target: 32-bit pci target answering burst reads
// assumes resolved frame and irdy wires
`timescale 1ns/1ps
module pmr_target #(
    parameter logic [31:0] DBASE = 32'h5a00_0000
) (
    input wire logic aclk,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic [1:0] waits,
    output logic devsel_n,
    output logic trdy_n,
    output logic ack64_n,
    output logic [31:0] ad
);
    logic act = 1'b0;
    logic [1:0] w = 2'h0;
    logic [31:0] n = 32'h0;
    initial devsel_n = 1'b1;
    initial trdy_n = 1'b1;
    assign ack64_n = 1'b1;
    // released bus shows the inverse
    assign ad = trdy_n ? ~(DBASE + n) : DBASE + n;
    always @(posedge aclk) begin
        if (!act && !frame_n) begin
            act <= 1'b1;
            devsel_n <= 1'b0;
            w <= waits;
            n <= 32'h0;
        end else if (act && !trdy_n && !irdy_n) begin
            n <= n + 32'h1;
            // frame high: final phase
            if (frame_n) begin
                act <= 1'b0;
                devsel_n <= 1'b1;
                trdy_n <= 1'b1;
            end
        end else if (act && trdy_n) begin
            if (w == 2'h0) trdy_n <= 1'b0;
            else w <= w - 2'h1;
        end
    end
endmodule

// ===== verif/testbench.sv
// testbench: directed burst reads and register accesses on pmr_master
// assumes pmr_pkg, pmr_master, pmr_target and pmr_sva compiled first
`timescale 1ns/1ps
module testbench;
    import pmr_pkg::*;
    localparam logic [31:0] DBASE = 32'h5a00_0000;
    logic aclk = 0, aresetn = 0, gnt_n = 1, local_ready_n = 1;
    logic [AXI_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, ad_in, ad_out, tad, local_addr_in = 0;
    logic [3:0] s_axi_wstrb = 4'hf, cbe_out, local_cmd_byte_en_in = 0, local_master_state;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, req_n, frame_n_in, frame_n_out, frame_oe, irdy_n_in, irdy_n_out;
    logic irdy_oe, trdy_n, devsel_n, ack64_n, ad_oe, cbe_oe, local_grant_n;
    logic wide_transfer_active_n, low_lane_xfer_n, high_lane_xfer_n;
    logic local_req_narrow_n = 1, local_req_wide_n = 1;
    logic [1:0] s_axi_bresp, s_axi_rresp, end_cause_code, waits = 0;
    logic [LEN_W-1:0] local_burst_len_in = 0, burst_remaining_count;
    logic [63:0] local_data_out;
    int n_errors = 0, total_checks = 0, cyc = 0;
    // pull-ups on released frame and irdy
    assign frame_n_in = frame_oe ? frame_n_out : 1'b1;
    assign irdy_n_in = irdy_oe ? irdy_n_out : 1'b1;
    assign ad_in = ad_oe ? ad_out : tad;
    always #2 aclk = ~aclk;
    always @(posedge aclk) gnt_n <= req_n;
    pmr_master u_pmr_master (.*);
    pmr_target #(.DBASE(DBASE)) tgt (.aclk, .frame_n(frame_n_in), .irdy_n(irdy_n_in),
        .waits, .devsel_n, .trdy_n, .ack64_n, .ad(tad));
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    // ==========
    // axi4-lite master
    task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
        logic aw, w, b;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(negedge aclk);
            {aw, w} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
            {b, r} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end while (!b);
        s_axi_bready <= 0;
        chk(r, RESP_OKAY);
    endtask
    task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [1:0] er,
        input logic [31:0] ed);
        logic ar, b;
        logic [33:0] got;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            {b, got} = {s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 0;
        end while (!b);
        s_axi_rready <= 0;
        chk(got, {er, ed});
    endtask
    // ==========
    // local burst read
    task automatic run_burst(input logic [31:0] a, input logic [7:0] len, input logic zu,
        input logic [1:0] ws);
        int k = 0;
        logic hi = a[2];
        logic [31:0] qa = {a[31:3], 3'h0};
        @(posedge aclk);
        waits <= ws;
        local_req_narrow_n <= 0;
        local_addr_in <= a;
        local_cmd_byte_en_in <= 4'h6;
        local_burst_len_in <= len;
        do @(negedge aclk); while (local_master_state !== LMS_LOAD);
        @(posedge aclk);
        local_req_narrow_n <= 1;
        local_cmd_byte_en_in <= 4'h0;
        local_ready_n <= 0;
        @(negedge aclk);
        chk({ad_out, cbe_out, local_master_state}, {a, 4'h6, LMS_BUS});
        repeat (40) begin
            @(negedge aclk);
            if (!low_lane_xfer_n || !high_lane_xfer_n) begin
                chk({low_lane_xfer_n, high_lane_xfer_n, hi ? local_data_out[63:32] :
                    local_data_out[31:0]}, {hi, !hi, DBASE + k});
                if (zu && !hi) chk(local_data_out[63:32], 0);
                k++;
                if (hi) qa += 32'h8;
                hi = !hi;
            end
            if (local_master_state === LMS_TERM) begin
                chk({end_cause_code, wide_transfer_active_n}, {END_NORMAL, 1'b1});
                break;
            end
        end
        chk(k, len);
        chk(qa, {a[31:3], 3'h0} + 32'h8 * ((len + a[2]) >> 1));
        @(posedge aclk);
        local_ready_n <= 1;
    endtask
    task automatic t_regs();
        axi_rd(REG_CTRL, RESP_OKAY, 32'h1);
        axi_rd(8'h0c, RESP_SLVERR, 32'h0);
        axi_wr(REG_STATUS, 32'hffff_ffff);
        axi_rd(REG_STATUS, RESP_OKAY, 32'h0);
    endtask
    task automatic t_unaligned();
        run_burst(32'h0000_1004, 8'h03, 1'b0, 2'h2);
    endtask
    task automatic t_aligned();
        axi_wr(REG_CTRL, 32'h3);
        run_burst(32'h0000_2000, 8'h04, 1'b1, 2'h0);
        axi_rd(REG_COUNT, RESP_OKAY, 32'h7);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_regs();
        t_unaligned();
        t_aligned();
        conclude();
    end
endmodule
